// >>> hw/dsl_pkg.sv
package dsl_pkg;

  // Counter widths of the link
  localparam int PERIOD_W = 16;
  localparam int CNT_W = 22;

  // Character framing: start bit, eight data bits, stop bit
  localparam logic [3:0] IDX_START = 4'h0;
  localparam logic [3:0] IDX_LAST_DATA = 4'h8;
  localparam logic [3:0] IDX_STOP = 4'h9;

  // The calibration character is low for start plus seven zero bits
  localparam int CAL_LOW_SHIFT = 3;

  // Bit counts for break detection and the returned error break
  localparam logic [CNT_W-1:0] BREAK_BITS = 22'h000009;
  localparam logic [CNT_W-1:0] ERR_BREAK_BITS = 22'h000028;

  // Shortest usable bit period in clock cycles
  localparam logic [PERIOD_W-1:0] MIN_PERIOD = 16'h0004;

  // Unlock key
  localparam int KEY_W = 32;
  localparam logic [2:0] KEY_BYTES = 3'h4;
  localparam logic [KEY_W-1:0] KEY_DEFAULT = 32'h5A3C_96E1; // Arbitrary value

  typedef enum logic [2:0] {
    ST_AUTOBAUD = 3'b000,
    ST_MEASURE = 3'b001,
    ST_IDLE = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_ERRBRK = 3'b101,
    ST_WAITHIGH = 3'b110
  } dsl_state_type;

  typedef struct packed {
    dsl_state_type state;
    logic [CNT_W-1:0] ctr;
    logic [CNT_W-1:0] low_run;
    logic [3:0] bit_idx;
    logic [7:0] shift;
    logic [PERIOD_W-1:0] period;
    logic drive;
    logic rx_done;
    logic abort;
  } dsl_link_type;

  typedef struct packed {
    logic debug_mode;
    logic first;
    logic halt_exit;
    logic wdt_refresh;
    logic periph_run;
    logic [KEY_W-1:0] key_sh;
    logic [2:0] key_cnt;
    logic unlocked;
  } dsl_dbg_type;

endpackage

// >>> hw/dsl_debug_link.sv
`timescale 1ns/1ps
// What this block does
// RULE_01 - In debug mode the core stops fetching; it runs only directed instructions.
// RULE_02 - Clock and enabled peripherals keep running in debug mode unless stopped.
// RULE_03 - Entering debug mode forces the core out of halt.
// RULE_04 - In debug mode the enabled watchdog is refreshed continuously.
// RULE_05 - Executing the breakpoint instruction enters debug mode.
// RULE_06 - Debug pin low in the last reset cycle enters debug mode after reset.
// RULE_07 - Host should hold the pin low 5000 more cycles after reset.
// RULE_08 - Key of 32 bits shifted while reset pin held low unlocks debug.
// RULE_09 - Host baud at most clock/8; clock/4 is an absolute limit.
// RULE_10 - Nine or more bit times low is a break; it resets auto-baud.
// RULE_11 - After a break the host sends 80H for rate measurement.
// RULE_12 - Detect break, framing error and transmit collision on the line.
// RULE_13 - Any line error aborts, sends a four-character break, resets auto-baud.
// RULE_14 - Host sends a break on connect and on error recovery.
// RULE_15 - Host break resets only auto-baud; debug mode and control stay.
// RULE_16 - The link stays in reset until the line returns high.
// RULE_17 - Open-drain line; a host break during transmit is caught as error.
// RULE_18 - Low time of 80H measured in clocks sets rx and tx bit period.
// RULE_19 - Idle high, low start, eight data bits LSB first, high stop.
module dsl_debug_link import dsl_pkg::*; #(
  parameter logic [KEY_W-1:0] UNLOCK_KEY = KEY_DEFAULT
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Core side
  input wire logic brk_executed,
  input wire logic debug_exit,
  input wire logic stop_mode,
  input wire logic wdt_enabled,
  output logic debug_mode_q,
  output logic halt_exit_q,
  output logic wdt_refresh_q,
  output logic periph_run_q,
  output logic unlocked_q,
  // Command bytes to and from the debug logic
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready_q,
  output logic [7:0] rx_data_q,
  output logic rx_valid_q,
  output logic abort_q,
  output logic link_reset_q,
  output logic baud_locked_q,
  // Pins
  input wire logic debug_serial_pin_i,
  output logic debug_serial_pin_o,
  output logic debug_serial_pin_oe,
  input wire logic shared_reset_pin_i
);

  logic [1:0] pin_sync_q;
  logic [1:0] rstpin_sync_q;
  logic line;
  logic rstpin_low;
  dsl_link_type link_q, link_d;
  dsl_dbg_type dbg_q, dbg_d;
  logic [7:0] buf_mem_q [2];
  logic [7:0] buf_mem_d [2];
  logic buf_wr_q, buf_wr_d, buf_rd_q, buf_rd_d;
  logic [1:0] buf_cnt_q, buf_cnt_d;
  logic tx_ready_d;
  logic push, pop;
  logic [PERIOD_W-1:0] half;
  logic [CNT_W-1:0] period_w, brk_lim, err_lim;
  logic bit_end, mid_bit, line_err;

  // Synchronisers run through reset so the last reset cycle is seen
  always_ff @(posedge clk) begin
    if (clk_en) begin
      pin_sync_q <= {pin_sync_q[0], debug_serial_pin_i};
      rstpin_sync_q <= {rstpin_sync_q[0], shared_reset_pin_i};
    end
  end

  assign line = pin_sync_q[1];
  assign rstpin_low = ~rstpin_sync_q[1];
  assign debug_serial_pin_o = 1'b0; // Open drain: only ever pulls low [RULE_17]

  assign half = link_q.period >> 1;
  assign period_w = CNT_W'(link_q.period);
  assign brk_lim = CNT_W'(period_w * BREAK_BITS); // [RULE_10]
  assign err_lim = CNT_W'(period_w * ERR_BREAK_BITS); // [RULE_13]
  assign bit_end = (link_q.ctr == period_w - CNT_W'(1));
  assign mid_bit = (link_q.ctr == CNT_W'(half));

  // Link state machine
  always_comb begin
    link_d = link_q;
    link_d.rx_done = 1'b0;
    link_d.abort = 1'b0;
    line_err = 1'b0;
    pop = 1'b0;
    link_d.low_run = line ? '0 : link_q.low_run + ((&link_q.low_run) ? '0 : CNT_W'(1));
    unique case (link_q.state)
      ST_AUTOBAUD: begin
        link_d.period = '0;
        if (!line) begin
          link_d.state = ST_MEASURE;
          link_d.ctr = CNT_W'(1);
        end
      end
      ST_MEASURE: begin
        if (!line) begin
          link_d.ctr = link_q.ctr + CNT_W'(1);
          if (&link_q.ctr) link_d.state = ST_WAITHIGH;
        end else begin
          link_d.period = PERIOD_W'(link_q.ctr >> CAL_LOW_SHIFT); // [RULE_18] [RULE_11]
          if ((link_q.ctr >> CAL_LOW_SHIFT) < CNT_W'(MIN_PERIOD)) begin
            link_d.state = ST_WAITHIGH; // [RULE_09]
          end else begin
            link_d.state = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        link_d.ctr = '0;
        link_d.bit_idx = IDX_START;
        if (!line) begin
          link_d.state = ST_RX;
        end else if (buf_cnt_q != 2'h0) begin
          link_d.state = ST_TX;
          link_d.shift = buf_mem_q[buf_rd_q];
          pop = 1'b1;
        end
      end
      ST_RX: begin
        link_d.ctr = bit_end ? '0 : link_q.ctr + CNT_W'(1);
        if (bit_end) link_d.bit_idx = link_q.bit_idx + 4'h1;
        if (link_q.low_run >= brk_lim) begin
          line_err = 1'b1; // [RULE_10] [RULE_12]
        end else if (mid_bit) begin
          if (link_q.bit_idx == IDX_START) begin
            if (line) link_d.state = ST_IDLE;
          end else if (link_q.bit_idx <= IDX_LAST_DATA) begin
            link_d.shift = {line, link_q.shift[7:1]}; // [RULE_19]
          end else if (!line) begin
            line_err = 1'b1; // Framing error [RULE_12]
          end else begin
            link_d.rx_done = 1'b1;
            link_d.state = ST_IDLE;
          end
        end
      end
      ST_TX: begin
        link_d.ctr = bit_end ? '0 : link_q.ctr + CNT_W'(1);
        if (mid_bit && !link_q.drive && !line) begin
          line_err = 1'b1; // Collision or host break [RULE_12] [RULE_17]
        end else if (bit_end) begin
          link_d.bit_idx = link_q.bit_idx + 4'h1;
          if (link_q.bit_idx != IDX_START) link_d.shift = link_q.shift >> 1;
          if (link_q.bit_idx == IDX_STOP) link_d.state = ST_IDLE;
        end
      end
      ST_ERRBRK: begin
        link_d.ctr = link_q.ctr + CNT_W'(1);
        if (link_q.ctr >= err_lim - CNT_W'(1)) link_d.state = ST_WAITHIGH; // [RULE_13]
      end
      ST_WAITHIGH: begin
        if (line) link_d.state = ST_AUTOBAUD; // [RULE_16]
      end
      default: link_d.state = ST_WAITHIGH;
    endcase
    if (line_err) begin
      link_d.state = ST_ERRBRK; // [RULE_13]
      link_d.ctr = '0;
      link_d.abort = 1'b1;
    end
    unique case (link_d.state)
      ST_ERRBRK: link_d.drive = 1'b1;
      ST_TX: link_d.drive = (link_d.bit_idx == IDX_START) ||
        ((link_d.bit_idx <= IDX_LAST_DATA) && !link_d.shift[0]); // [RULE_19]
      default: link_d.drive = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_q <= '{state: ST_AUTOBAUD, default: '0};
    end else if (clk_en) begin
      link_q <= link_d;
    end
  end

  // Two-entry transmit buffer; the transmitter drains it only when idle
  assign push = tx_valid && tx_ready_q;

  always_comb begin
    buf_mem_d = buf_mem_q;
    buf_wr_d = buf_wr_q;
    buf_rd_d = buf_rd_q;
    buf_cnt_d = buf_cnt_q;
    if (link_d.abort) begin
      buf_wr_d = 1'b0;
      buf_rd_d = 1'b0;
      buf_cnt_d = 2'h0; // [RULE_13]
    end else begin
      if (push) begin
        buf_mem_d[buf_wr_q] = tx_data;
        buf_wr_d = ~buf_wr_q;
      end
      if (pop) buf_rd_d = ~buf_rd_q;
      buf_cnt_d = buf_cnt_q + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
    end
    tx_ready_d = (buf_cnt_d != 2'h2);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_mem_q <= '{default: 8'h00};
      buf_wr_q <= 1'b0;
      buf_rd_q <= 1'b0;
      buf_cnt_q <= 2'h0;
      tx_ready_q <= 1'b0;
    end else if (clk_en) begin
      buf_mem_q <= buf_mem_d;
      buf_wr_q <= buf_wr_d;
      buf_rd_q <= buf_rd_d;
      buf_cnt_q <= buf_cnt_d;
      tx_ready_q <= tx_ready_d;
    end
  end

  // Debug mode, core controls and unlock
  always_comb begin
    dbg_d = dbg_q;
    dbg_d.first = 1'b0;
    dbg_d.halt_exit = 1'b0;
    if (brk_executed && !dbg_q.debug_mode) begin
      dbg_d.debug_mode = 1'b1; // [RULE_05]
      dbg_d.halt_exit = 1'b1; // [RULE_03]
    end else if (dbg_q.first && !line) begin
      dbg_d.debug_mode = 1'b1; // [RULE_06]
      dbg_d.halt_exit = 1'b1; // [RULE_03]
    end else if (debug_exit) begin
      dbg_d.debug_mode = 1'b0; // Link errors leave this untouched [RULE_15]
    end
    dbg_d.wdt_refresh = dbg_d.debug_mode && wdt_enabled; // [RULE_04]
    dbg_d.periph_run = !stop_mode; // [RULE_02]
    if (!rstpin_low) begin
      dbg_d.key_cnt = 3'h0;
    end else if (link_q.rx_done && dbg_q.key_cnt != KEY_BYTES) begin
      dbg_d.key_sh = {dbg_q.key_sh[KEY_W-9:0], link_q.shift}; // [RULE_08]
      dbg_d.key_cnt = dbg_q.key_cnt + 3'h1;
    end
    if (dbg_q.key_cnt == KEY_BYTES && dbg_q.key_sh == UNLOCK_KEY) begin
      dbg_d.unlocked = 1'b1; // [RULE_08]
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbg_q <= '{first: 1'b1, default: '0};
    end else if (clk_en) begin
      dbg_q <= dbg_d;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      abort_q <= 1'b0;
      link_reset_q <= 1'b1;
      baud_locked_q <= 1'b0;
      debug_serial_pin_oe <= 1'b0;
    end else if (clk_en) begin
      rx_data_q <= link_d.rx_done ? link_d.shift : rx_data_q;
      rx_valid_q <= link_d.rx_done && dbg_q.unlocked;
      abort_q <= link_d.abort;
      link_reset_q <= (link_d.state == ST_ERRBRK) || (link_d.state == ST_WAITHIGH); // [RULE_16]
      baud_locked_q <= (link_d.period != '0);
      debug_serial_pin_oe <= link_d.drive;
    end
  end

  assign debug_mode_q = dbg_q.debug_mode; // Core fetch is stopped while high [RULE_01]
  assign halt_exit_q = dbg_q.halt_exit;
  assign wdt_refresh_q = dbg_q.wdt_refresh;
  assign periph_run_q = dbg_q.periph_run;
  assign unlocked_q = dbg_q.unlocked;

endmodule // dsl_debug_link

// >>> tb/dsl_debug_link_props.sv
`timescale 1ns/1ps
module dsl_debug_link_props import dsl_pkg::*; (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Core side
  input wire logic brk_executed,
  input wire logic debug_exit,
  input wire logic stop_mode,
  input wire logic wdt_enabled,
  input wire logic debug_mode_q,
  input wire logic halt_exit_q,
  input wire logic wdt_refresh_q,
  input wire logic periph_run_q,
  input wire logic unlocked_q,
  // Link
  input wire logic abort_q,
  input wire logic link_reset_q,
  input wire logic debug_serial_pin_o,
  input wire logic debug_serial_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  brk_entry_a: assert property (
    clk_en && brk_executed && !debug_mode_q |=> debug_mode_q) else $error("no debug entry");
  halt_pulse_a: assert property (
    $rose(debug_mode_q) |-> halt_exit_q ##1 !halt_exit_q) else $error("halt exit bad");
  wdt_refresh_a: assert property (
    clk_en |=> wdt_refresh_q == (debug_mode_q && $past(wdt_enabled))) else $error("wdt bad");
  periph_run_a: assert property (
    clk_en |=> periph_run_q == !$past(stop_mode)) else $error("periph run bad");
  mode_hold_a: assert property (
    debug_mode_q && !debug_exit |=> debug_mode_q) else $error("debug mode lost");
  err_break_a: assert property (
    abort_q |-> ##[0:2] (debug_serial_pin_oe && link_reset_q)) else $error("no error break");
  pin_low_a: assert property (
    debug_serial_pin_o == 1'b0) else $error("pin drives high");
  unlock_hold_a: assert property (
    unlocked_q |=> unlocked_q) else $error("unlock lost");
endmodule // dsl_debug_link_props
bind dsl_debug_link dsl_debug_link_props chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .clk_en(clk_en),
  .brk_executed(brk_executed),
  .debug_exit(debug_exit),
  .stop_mode(stop_mode),
  .wdt_enabled(wdt_enabled),
  .debug_mode_q(debug_mode_q),
  .halt_exit_q(halt_exit_q),
  .wdt_refresh_q(wdt_refresh_q),
  .periph_run_q(periph_run_q),
  .unlocked_q(unlocked_q),
  .abort_q(abort_q),
  .link_reset_q(link_reset_q),
  .debug_serial_pin_o(debug_serial_pin_o),
  .debug_serial_pin_oe(debug_serial_pin_oe)
);

// >>> tb/dsl_host_model.sv
`timescale 1ns/1ps
module dsl_host_model #(
  parameter int P = 8
) (
  // Line
  input wire logic clk,
  input wire logic dev_oe,
  output logic line
);
  logic low_q = 1'b0;
  logic [7:0] got[$];
  // Open-drain line with pull-up
  assign line = !(low_q || dev_oe);
  // Frame LSB first at clk/8
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      low_q <= !f[i];
      repeat (P) @(posedge clk);
    end
    low_q <= 1'b0;
    repeat (P) @(posedge clk);
  endtask
  // Break of n cycles
  task automatic hold(input int n);
    low_q <= 1'b1;
    repeat (n) @(posedge clk);
    low_q <= 1'b0;
  endtask
  always @(posedge dev_oe) begin : rx
    logic [7:0] s;
    repeat (P + P / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      s[i] = line;
      repeat (P) @(posedge clk);
    end
    got.push_back(s);
  end
endmodule // dsl_host_model

// >>> tb/tb_dsl_debug_link.sv
`timescale 1ns/1ps
module tb_dsl_debug_link import dsl_pkg::*;;
  localparam int P = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic brk_executed = 1'b0;
  logic debug_exit = 1'b0;
  logic stop_mode = 1'b0;
  logic wdt_enabled = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic shared_reset_pin_i = 1'b1;
  logic clk_en = 1'b1;
  logic debug_mode_q, halt_exit_q, wdt_refresh_q, periph_run_q, unlocked_q, tx_ready_q;
  logic rx_valid_q, abort_q, link_reset_q, baud_locked_q, pin_o, pin_oe, line;
  logic [7:0] rx_data_q;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_rx = 0;
  int n_ab = 0;
  int run = 0;
  int last_run = 0;
  always #2.5 clk = !clk;
  dsl_debug_link dut (.clk, .sys_rst, .clk_en, .brk_executed, .debug_exit, .stop_mode,
    .wdt_enabled, .debug_mode_q, .halt_exit_q, .wdt_refresh_q, .periph_run_q, .unlocked_q,
    .tx_data, .tx_valid, .tx_ready_q, .rx_data_q, .rx_valid_q, .abort_q, .link_reset_q,
    .baud_locked_q, .debug_serial_pin_i(line), .debug_serial_pin_o(pin_o),
    .debug_serial_pin_oe(pin_oe), .shared_reset_pin_i);
  dsl_host_model #(.P(P)) host (.clk, .dev_oe(pin_oe), .line);
  task automatic test_done();
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Pulse counters and length of each device low drive
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_valid_q === 1'b1) n_rx <= n_rx + 1;
    if (abort_q === 1'b1) n_ab <= n_ab + 1;
    if (pin_oe === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic push(input logic [7:0] b);
    int w;
    tx_data <= b;
    tx_valid <= 1'b1;
    w = 0;
    do begin
      tick(1);
      w++;
    end while (tx_ready_q !== 1'b1 && w < 3000);
  endtask
  // Wait out the returned break, then calibrate again
  task automatic recover(input int a0);
    int w;
    w = 0;
    while ((n_ab == a0 || pin_oe === 1'b1) && w < 3000) begin
      tick(1);
      w++;
    end
    tick(2);
    chk(link_reset_q, 1);
    chk(pin_o, 1'b0);
    chk(n_ab - a0, 1);
    chk(last_run >= 40 * P - 2 && last_run <= 40 * P + 2, 1);
    chk(debug_mode_q, 1);
    tick(8);
    chk(link_reset_q, 0);
    chk(baud_locked_q, 0);
    host.send(8'h80, 1'b1);
    chk(baud_locked_q, 1);
  endtask
  task automatic t_core();
    chk(debug_mode_q, 0);
    // Frozen by the clock enable, the breakpoint must not be taken yet
    clk_en <= 1'b0;
    brk_executed <= 1'b1;
    stop_mode <= 1'b1;
    tick(2);
    chk(debug_mode_q, 0);
    clk_en <= 1'b1;
    tick(1);
    brk_executed <= 1'b0;
    tick(1);
    chk(debug_mode_q, 1);
    chk(halt_exit_q, 1);
    chk(periph_run_q, 0);
    tick(1);
    chk(wdt_refresh_q, 1);
    stop_mode <= 1'b0;
    wdt_enabled <= 1'b0;
    tick(2);
    chk(wdt_refresh_q, 0);
    chk(periph_run_q, 1);
    wdt_enabled <= 1'b1;
  endtask
  task automatic t_cal();
    host.send(8'h80, 1'b1);
    chk(baud_locked_q, 1);
  endtask
  task automatic t_unlock();
    shared_reset_pin_i <= 1'b0;
    tick(4);
    for (int i = 3; i >= 0; i--) host.send(KEY_DEFAULT[8*i+:8], 1'b1);
    chk(n_rx, 0);
    chk(unlocked_q, 1);
    shared_reset_pin_i <= 1'b1;
    host.send(8'hA5, 1'b1);
    chk(rx_data_q, 8'hA5);
    chk(n_rx, 1);
  endtask
  task automatic t_tx();
    logic [7:0] e[4];
    int w;
    e = '{8'h3C, 8'hC3, 8'h81, 8'h7E};
    host.got.delete();
    for (int i = 0; i < 3; i++) push(e[i]);
    tx_data <= e[3];
    tick(1);
    chk(tx_ready_q, 0);
    push(e[3]);
    tx_valid <= 1'b0;
    w = 0;
    while (host.got.size() < 4 && w < 3000) begin
      tick(1);
      w++;
    end
    for (int i = 0; i < 4; i++) chk(host.got[i], e[i]);
  endtask
  task automatic t_errors();
    int a;
    int w;
    tick(2 * P);
    a = n_ab;
    host.hold(10 * P);
    // A break is caught before the stop bit could flag a framing error
    chk(n_ab - a, 1);
    recover(a);
    a = n_ab;
    host.send(8'hFF, 1'b0);
    recover(a);
    a = n_ab;
    push(8'hFF);
    tx_valid <= 1'b0;
    w = 0;
    while (pin_oe !== 1'b1 && w < 500) begin
      tick(1);
      w++;
    end
    tick(2 * P);
    host.low_q <= 1'b1;
    tick(P);
    // Collision is seen within the bit, long before a break could count
    chk(n_ab - a, 1);
    tick(9 * P);
    host.low_q <= 1'b0;
    recover(a);
  endtask
  task automatic t_reset_entry();
    debug_exit <= 1'b1;
    tick(1);
    debug_exit <= 1'b0;
    tick(1);
    chk(debug_mode_q, 0);
    sys_rst <= 1'b1;
    host.low_q <= 1'b1;
    tick(3);
    sys_rst <= 1'b0;
    tick(2);
    chk(debug_mode_q, 1);
    chk(halt_exit_q, 1);
    tick(5000);
    host.low_q <= 1'b0;
  endtask
  initial begin
    tick(2);
    sys_rst <= 1'b0;
    tick(2);
    t_cal();
    t_core();
    t_unlock();
    t_tx();
    t_errors();
    t_reset_entry();
    test_done();
  end
endmodule // tb_dsl_debug_link
